// ### pic_pkg.sv
// Purpose: Constants and types for the prioritised interrupt controller.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses within the controller window.
package pic_pkg;
    // ========================================================
    // Register offsets
    localparam logic [11:0] OFS_N_MSTAT  = 12'h000;
    localparam logic [11:0] OFS_N_RAW    = 12'h004;
    localparam logic [11:0] OFS_N_ENSET  = 12'h008;
    localparam logic [11:0] OFS_N_ENCLR  = 12'h00c;
    localparam logic [11:0] OFS_SWREQ    = 12'h010;
    localparam logic [11:0] OFS_P_MSTAT  = 12'h020;
    localparam logic [11:0] OFS_P_RAW    = 12'h024;
    localparam logic [11:0] OFS_P_ENSET  = 12'h028;
    localparam logic [11:0] OFS_P_ENCLR  = 12'h02c;
    localparam logic [11:0] OFS_PRIO0    = 12'h040;
    localparam logic [11:0] OFS_PRIO3    = 12'h04c;
    localparam logic [11:0] OFS_WIN      = 12'h050;
    localparam logic [11:0] OFS_THR      = 12'h054;
    localparam logic [11:0] OFS_N_MODE   = 12'h080;
    localparam logic [11:0] OFS_N_POL    = 12'h084;
    localparam logic [11:0] OFS_N_TRCLR  = 12'h088;
    localparam logic [11:0] OFS_P_MODE   = 12'h0a0;
    localparam logic [11:0] OFS_P_POL    = 12'h0a4;
    localparam logic [11:0] OFS_P_TRCLR  = 12'h0a8;
    localparam logic [11:0] OFS_F_MSTAT  = 12'h100;
    localparam logic [11:0] OFS_F_RAW    = 12'h104;
    localparam logic [11:0] OFS_F_ENSET  = 12'h108;
    localparam logic [11:0] OFS_F_ENCLR  = 12'h10c;
    localparam logic [11:0] OFS_F_MODE   = 12'h180;
    localparam logic [11:0] OFS_F_POL    = 12'h184;
    localparam logic [11:0] OFS_F_TRCLR  = 12'h188;
    // ========================================================
    // Window and field layout
    localparam logic [31:0] BASE_ADDR    = 32'hffff_f000;
    localparam logic [19:0] BASE_HI      = 20'hfffff;
    localparam int          SW_BIT       = 1;
    localparam int          PIN_REP_BIT  = 20;
    localparam int          PRIO_STRIDE  = 4;
    localparam int          PRIO_PER_REG = 8;
    localparam logic [3:0]  THR_NONE     = 4'hf;
    localparam logic [7:0]  NONE_CODE    = 8'hff;
    // ========================================================
    // Reset values
    localparam logic [31:0] N_POL_RST    = 32'hffff_ffff;
    localparam logic [11:0] P_POL_RST    = 12'hfff;
    localparam logic [1:0]  F_POL_RST    = 2'h3;
    localparam logic [7:0]  THR_RST      = 8'hff;
    // ========================================================
    // Arbitration result
    typedef struct packed {
        logic [7:0] prio;
        logic [7:0] num;
    } pic_win_s;
    localparam pic_win_s WIN_NONE = '{prio: NONE_CODE, num: NONE_CODE};
endpackage

// ### pic_top.sv
// Purpose: Prioritised interrupt controller with normal, pin and fast groups.
// Assumes: UNIT_REQ and WDT_FAST_REQ come from logic on CLOCK; PORT_B_PINS
//          are asynchronous pins, active low.
// Notes:   APB answers with no wait state; read data is captured in setup.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module pic_top (
    // Clock and reset
    input  wire logic          CLOCK,
    input  wire logic          RESET,
    // APB slave
    input  wire logic          PSEL,
    input  wire logic          PENABLE,
    input  wire logic          PWRITE,
    input  wire logic [31:0]   PADDR,
    input  wire logic [31:0]   PWDATA,
    output logic      [31:0]   PRDATA,
    output logic               PREADY,
    output logic               PSLVERR,
    // Interrupt sources
    input  wire logic [31:0]   UNIT_REQ,
    input  wire logic          WDT_FAST_REQ,
    input  wire logic [7:0]    PORT_B_PINS,
    // Core lines, active low
    output logic               CORE_NORMAL_LINE_N,
    output logic               CORE_FAST_LINE_N
);
    import pic_pkg::*;

    // ========================================================
    // Helpers
    // Active level after polarity: 1 selects high level / rising
    function automatic logic [31:0] pol_apply(input logic [31:0] s,
                                              input logic [31:0] p);
        pol_apply = ~(s ^ p);
    endfunction

    // Edge latch: a new edge wins over a clear in the same cycle
    function automatic logic [31:0] edge_next(input logic [31:0] lat,
                                              input logic [31:0] act,
                                              input logic [31:0] prv,
                                              input logic [31:0] clr);
        edge_next = (lat & ~clr) | (act & ~prv);
    endfunction

    // ========================================================
    // Register state
    logic [31:0] en_n_q, mode_n_q, pol_n_q, lat_n_q, prv_n_q;
    logic [7:0]  en_p_q, mode_p_q, lat_p_q, prv_p_q;
    logic [11:0] pol_p_q;
    logic [1:0]  en_f_q, mode_f_q, pol_f_q, lat_f_q, prv_f_q;
    logic        sw_q;
    logic [1:0]  prio_q [32];
    logic [7:0]  thr_q;
    pic_win_s    win_q, win_d;
    logic [7:0]  pin_s1_q, pin_s2_q;
    logic [31:0] rdata_q;
    logic        err_q;
    logic        nline_q, fline_q;

    // ========================================================
    // APB decode
    logic        in_win, wr, setup;
    logic [11:0] ofs;
    assign in_win = (PADDR[31:12] == BASE_HI);
    assign ofs    = PADDR[11:0];
    assign setup  = PSEL & ~PENABLE;
    assign wr     = PSEL & PENABLE & PWRITE & in_win;
    assign PREADY = 1'b1;

    // ========================================================
    // Pin synchroniser; pins are active low, so invert after sync
    // Reset to the idle high level: a zero here would look like a
    // pin edge right after reset and show the pins active in the raw status.
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
        end else begin
            pin_s1_q <= PORT_B_PINS;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ========================================================
    // Source conditioning
    logic [31:0] src_n, act_n, raw_n, msk_n, act_p, raw_p, act_f, raw_f;
    logic [7:0]  msk_p;
    logic [1:0]  msk_f;
    logic [7:0]  pin_hi;
    assign pin_hi = ~pin_s2_q;
    // Pin group conditioned separately
    assign act_p = pol_apply({24'h0, pin_hi}, {20'h0, pol_p_q});
    assign raw_p = {24'h0, mode_p_q & lat_p_q[7:0] | ~mode_p_q & act_p[7:0]};
    assign msk_p = raw_p[7:0] & en_p_q;
    // Normal sources: software bit and pin-group representative replace units
    always_comb begin
        src_n              = UNIT_REQ;
        src_n[SW_BIT]      = sw_q;
        src_n[PIN_REP_BIT] = |msk_p;
    end
    assign act_n = pol_apply(src_n, pol_n_q);
    assign raw_n = (mode_n_q & lat_n_q) | (~mode_n_q & act_n);
    assign msk_n = raw_n & en_n_q;
    // Fast group: watchdog and port B pin 0
    assign act_f = pol_apply({30'h0, pin_hi[0], WDT_FAST_REQ}, {30'h0, pol_f_q});
    assign raw_f = {30'h0, (mode_f_q & lat_f_q) | (~mode_f_q & act_f[1:0])};
    assign msk_f = raw_f[1:0] & en_f_q;

    // ========================================================
    // Edge detectors and latches, one per group
    // Latches arm only in edge mode, so activity seen while an input
    // was in level mode never shows up later as a stale edge.
    logic [31:0] lat_n_d, lat_p_d, lat_f_d;
    assign lat_n_d = edge_next(lat_n_q, act_n & mode_n_q, prv_n_q,
                               (wr && ofs == OFS_N_TRCLR) ? PWDATA : 32'h0);
    assign lat_p_d = edge_next({24'h0, lat_p_q}, act_p & {24'h0, mode_p_q}, {24'h0, prv_p_q},
                               (wr && ofs == OFS_P_TRCLR) ? PWDATA : 32'h0);
    assign lat_f_d = edge_next({30'h0, lat_f_q}, act_f & {30'h0, mode_f_q}, {30'h0, prv_f_q},
                               (wr && ofs == OFS_F_TRCLR) ? PWDATA : 32'h0);
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            lat_n_q <= '0;
            prv_n_q <= '0;
            lat_p_q <= '0;
            prv_p_q <= '0;
            lat_f_q <= '0;
            prv_f_q <= '0;
        end else begin
            lat_n_q <= lat_n_d;
            prv_n_q <= act_n;
            lat_p_q <= lat_p_d[7:0];
            prv_p_q <= act_p[7:0];
            lat_f_q <= lat_f_d[1:0];
            prv_f_q <= act_f[1:0];
        end
    end

    // ========================================================
    // Enables: separate set and clear addresses, so no conflict
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            en_n_q <= '0;
            en_p_q <= '0;
            en_f_q <= '0;
        end else if (wr) begin
            case (ofs)
                OFS_N_ENSET: en_n_q <= en_n_q | PWDATA;
                OFS_N_ENCLR: en_n_q <= en_n_q & ~PWDATA;
                OFS_P_ENSET: en_p_q <= en_p_q | PWDATA[7:0];
                OFS_P_ENCLR: en_p_q <= en_p_q & ~PWDATA[7:0];
                OFS_F_ENSET: en_f_q <= en_f_q | PWDATA[1:0];
                OFS_F_ENCLR: en_f_q <= en_f_q & ~PWDATA[1:0];
                default: ;
            endcase
        end
    end

    // ========================================================
    // Mode, polarity, software request and threshold
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            mode_n_q <= '0;
            pol_n_q  <= N_POL_RST;
            mode_p_q <= '0;
            pol_p_q  <= P_POL_RST;
            mode_f_q <= '0;
            pol_f_q  <= F_POL_RST;
            sw_q     <= 1'b0;
            thr_q    <= THR_RST;
        end else if (wr) begin
            case (ofs)
                OFS_N_MODE: mode_n_q <= PWDATA;
                OFS_N_POL:  pol_n_q  <= PWDATA;
                OFS_P_MODE: mode_p_q <= PWDATA[7:0];
                OFS_P_POL:  pol_p_q  <= PWDATA[11:0];
                OFS_F_MODE: mode_f_q <= PWDATA[1:0];
                OFS_F_POL:  pol_f_q  <= PWDATA[1:0];
                OFS_SWREQ:  sw_q     <= PWDATA[SW_BIT];
                OFS_THR:    thr_q    <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // ========================================================
    // Priority fields, two bits every fourth bit position
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            for (int i = 0; i < 32; i++) begin
                prio_q[i] <= '0;
            end
        end else if (wr && ofs >= OFS_PRIO0 && ofs <= OFS_PRIO3 && ofs[1:0] == 2'h0) begin
            for (int k = 0; k < PRIO_PER_REG; k++) begin
                prio_q[ofs[3:2] * PRIO_PER_REG + k] <= PWDATA[k * PRIO_STRIDE +: 2];
            end
        end
    end

    // ========================================================
    // Arbitration: scan downward so equal priority keeps the lower number
    logic [31:0] elig;
    always_comb begin
        win_d = WIN_NONE;
        for (int i = 31; i >= 0; i--) begin
            if (msk_n[i] && (win_d.prio == NONE_CODE || {6'h0, prio_q[i]} >= win_d.prio)) begin
                win_d.prio = {6'h0, prio_q[i]};
                win_d.num  = 8'(i);
            end
        end
        for (int i = 0; i < 32; i++) begin
            elig[i] = msk_n[i] && (thr_q[3:0] == THR_NONE || {2'h0, prio_q[i]} > thr_q[3:0]);
        end
    end

    // Winner and core lines registered to keep outputs glitch free
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            win_q   <= WIN_NONE;
            nline_q <= 1'b0;
            fline_q <= 1'b0;
        end else begin
            win_q   <= win_d;
            nline_q <= |elig;
            fline_q <= |msk_f;
        end
    end
    assign CORE_NORMAL_LINE_N = ~nline_q;
    assign CORE_FAST_LINE_N   = ~fline_q;

    // ========================================================
    // Read mux; captured in setup so PRDATA comes from a flip-flop
    logic [31:0] rd_d;
    logic        hit_d;
    always_comb begin
        rd_d  = '0;
        hit_d = 1'b1;
        case (ofs)
            OFS_N_MSTAT: rd_d = msk_n;
            OFS_N_RAW:   rd_d = raw_n;
            OFS_N_ENSET: rd_d = en_n_q;
            OFS_P_MSTAT: rd_d = {24'h0, msk_p};
            OFS_P_RAW:   rd_d = raw_p;
            OFS_P_ENSET: rd_d = {24'h0, en_p_q};
            OFS_WIN:     rd_d = {16'h0, win_q};
            OFS_THR:     rd_d = {24'h0, thr_q};
            OFS_N_MODE:  rd_d = mode_n_q;
            OFS_N_POL:   rd_d = pol_n_q;
            OFS_P_MODE:  rd_d = {24'h0, mode_p_q};
            OFS_P_POL:   rd_d = {20'h0, pol_p_q};
            OFS_F_MSTAT: rd_d = {30'h0, msk_f};
            OFS_F_RAW:   rd_d = raw_f;
            OFS_F_ENSET: rd_d = {30'h0, en_f_q};
            OFS_F_MODE:  rd_d = {30'h0, mode_f_q};
            OFS_F_POL:   rd_d = {30'h0, pol_f_q};
            // Write-only registers read as zero
            OFS_N_ENCLR, OFS_SWREQ, OFS_P_ENCLR, OFS_N_TRCLR,
            OFS_P_TRCLR, OFS_F_ENCLR, OFS_F_TRCLR: rd_d = '0;
            default: begin
                hit_d = 1'b0;
                if (ofs >= OFS_PRIO0 && ofs <= OFS_PRIO3 && ofs[1:0] == 2'h0) begin
                    hit_d = 1'b1;
                    for (int k = 0; k < PRIO_PER_REG; k++) begin
                        rd_d[k * PRIO_STRIDE +: 2] = prio_q[ofs[3:2] * PRIO_PER_REG + k];
                    end
                end
            end
        endcase
        if (!in_win) begin
            rd_d  = '0;
            hit_d = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            rdata_q <= '0;
            err_q   <= 1'b0;
        end else if (setup) begin
            rdata_q <= PWRITE ? 32'h0 : rd_d;
            err_q   <= ~hit_d;
        end
    end
    assign PRDATA  = rdata_q;
    // Unmapped access answers with an error in the access phase
    assign PSLVERR = PSEL & PENABLE & err_q;

    // ========================================================
    // Checks
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);

    property p_mask;
        msk_n == (raw_n & en_n_q);
    endproperty
    a_mask: assert property (p_mask) else $error("masked status wrong");

    property p_enset;
        (wr && ofs == OFS_N_ENSET) |=> ((en_n_q & $past(PWDATA)) == $past(PWDATA));
    endproperty
    a_enset: assert property (p_enset) else $error("enable set lost");

    property p_enclr;
        (wr && ofs == OFS_N_ENCLR) |=> ((en_n_q & $past(PWDATA)) == 32'h0);
    endproperty
    a_enclr: assert property (p_enclr) else $error("enable clear lost");

    property p_latclr;
        (|(lat_n_q & ~lat_n_d)) |-> (wr && ofs == OFS_N_TRCLR);
    endproperty
    a_latclr: assert property (p_latclr) else $error("edge latch cleared without write");

    property p_idle;
        (msk_n == 32'h0) |=> (win_q == WIN_NONE);
    endproperty
    a_idle: assert property (p_idle) else $error("winner not idle code");

    property p_thr;
        !CORE_NORMAL_LINE_N |-> $past(|elig);
    endproperty
    a_thr: assert property (p_thr) else $error("normal line without eligible cause");

    property p_fast;
        (|msk_f) |=> !CORE_FAST_LINE_N;
    endproperty
    a_fast: assert property (p_fast) else $error("fast line not raised");

    property p_sw;
        (wr && ofs == OFS_SWREQ) |=> (sw_q == $past(PWDATA[SW_BIT])) ##1 (src_n[SW_BIT] == $past(sw_q));
    endproperty
    a_sw: assert property (p_sw) else $error("software request not applied");

    property p_rep;
        (|msk_p && !mode_n_q[PIN_REP_BIT] && pol_n_q[PIN_REP_BIT]) |-> raw_n[PIN_REP_BIT];
    endproperty
    a_rep: assert property (p_rep) else $error("pin group not forwarded");

    property p_level;
        (!mode_n_q[0]) |-> (raw_n[0] == (UNIT_REQ[0] ~^ pol_n_q[0]));
    endproperty
    a_level: assert property (p_level) else $error("level status not following source");

    // Nothing enabled means nothing in masked status
    property p_dis;
        (en_n_q == 32'h0) |-> (msk_n == 32'h0);
    endproperty
    a_dis: assert property (p_dis) else $error("disabled input in masked status");

    // No masked cause, no normal request one cycle later
    property p_nline_idle;
        (msk_n == 32'h0) |=> CORE_NORMAL_LINE_N;
    endproperty
    a_nline_idle: assert property (p_nline_idle) else $error("normal line without masked cause");

    // Fast line drops once no fast cause is enabled
    property p_fline_idle;
        (msk_f == 2'h0) |=> CORE_FAST_LINE_N;
    endproperty
    a_fline_idle: assert property (p_fline_idle) else $error("fast line without masked cause");

endmodule // pic_top

// ### pic_core_model.sv
// Purpose: Behavioural stand-in for the core's two interrupt inputs.
// Assumes: Lines are active low and registered on clk.
// Notes:   Counts each new request the core would take.
`timescale 1ns/1ps
module pic_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Core lines, active low
    input  wire logic       normal_line_n,
    input  wire logic       fast_line_n,
    // Requests seen
    output logic [7:0]      normal_taken,
    output logic [7:0]      fast_taken
);
    logic n_prev_q;
    logic f_prev_q;
    // =====================================================
    // Falling edge counter; a held line counts only once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            n_prev_q     <= 1'b1;
            f_prev_q     <= 1'b1;
            normal_taken <= 8'h00;
            fast_taken   <= 8'h00;
        end else begin
            n_prev_q <= normal_line_n;
            f_prev_q <= fast_line_n;
            if (n_prev_q && !normal_line_n) begin
                normal_taken <= normal_taken + 8'h01;
            end
            if (f_prev_q && !fast_line_n) begin
                fast_taken <= fast_taken + 8'h01;
            end
        end
    end
endmodule // pic_core_model

// ### pic_top_tb.sv
// Purpose: Self-checking bench for the prioritised interrupt controller.
// Assumes: Zero-wait APB slave; core lines active low, registered.
// Notes:   One task per scenario; all waits are bounded.
`timescale 1ns/1ps
module pic_top_tb;
    import pic_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic [31:0] paddr, pwdata, prdata, rdata, unit_req;
    logic        wdt_req, irq_n, fiq_n;
    logic [7:0]  pins, n_taken, f_taken;
    int          num_errors = 0;
    int          n_checks = 0;
    // =====================================================
    // Design and core model
    pic_top u_pic_top (.CLOCK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .UNIT_REQ(unit_req), .WDT_FAST_REQ(wdt_req),
        .PORT_B_PINS(pins), .CORE_NORMAL_LINE_N(irq_n), .CORE_FAST_LINE_N(fiq_n));
    pic_core_model u_pic_core_model (.clk(clk), .rst(rst), .normal_line_n(irq_n),
        .fast_line_n(fiq_n), .normal_taken(n_taken), .fast_taken(f_taken));
    // =====================================================
    // Shared tasks
    task automatic end_sim();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Entered right after a rising edge; request held until pready
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        int i;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            num_errors++;
            end_sim();
        end
        rdata = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
        apb(1'b1, {BASE_HI, ofs}, d);
    endtask
    task automatic rd(input logic [11:0] ofs, input logic [31:0] exp);
        apb(1'b0, {BASE_HI, ofs}, 32'h0);
        chk(rdata, exp);
    endtask
    // Sample lines away from the edge that updates them
    task automatic line_chk(input logic n_exp, input logic f_exp);
        @(negedge clk);
        chk({30'h0, irq_n, fiq_n}, {30'h0, n_exp, f_exp});
        @(posedge clk);
    endtask
    // =====================================================
    // Scenarios
    task automatic t_reset();
        rd(OFS_N_RAW, 32'h0);
        rd(OFS_N_ENSET, 32'h0);
        rd(OFS_PRIO0, 32'h0);
        rd(OFS_WIN, 32'h0000_ffff);
        rd(OFS_THR, 32'h0000_00ff);
        rd(OFS_N_POL, 32'hffff_ffff);
        rd(OFS_P_POL, 32'h0000_0fff);
        rd(OFS_F_POL, 32'h0000_0003);
        line_chk(1'b1, 1'b1);
    endtask
    task automatic t_enable();
        unit_req <= 32'h0000_0030;
        @(posedge clk);
        rd(OFS_N_RAW, 32'h0000_0030);
        rd(OFS_N_MSTAT, 32'h0);
        wr(OFS_N_ENSET, 32'h0000_0020);
        wr(OFS_N_ENSET, 32'h0);
        rd(OFS_N_ENSET, 32'h0000_0020);
        rd(OFS_N_MSTAT, 32'h0000_0020);
        line_chk(1'b0, 1'b1);
        wr(OFS_N_ENCLR, 32'h0000_0010);
        rd(OFS_N_ENSET, 32'h0000_0020);
        wr(OFS_N_ENCLR, 32'h0000_0020);
        rd(OFS_N_ENSET, 32'h0);
        line_chk(1'b1, 1'b1);
    endtask
    // Inputs 5 and 6 tie at level 2, input 4 sits at level 1
    task automatic t_prio();
        unit_req <= 32'h0000_0070;
        wr(OFS_PRIO0, 32'h0e21_0000);
        rd(OFS_PRIO0, 32'h0221_0000);
        wr(OFS_N_ENSET, 32'h0000_0070);
        rd(OFS_WIN, 32'h0000_0205);
        wr(OFS_THR, 32'h0000_0002);
        line_chk(1'b1, 1'b1);
        wr(OFS_THR, 32'h0000_0001);
        line_chk(1'b0, 1'b1);
        wr(OFS_PRIO0, 32'h0321_0000);
        rd(OFS_WIN, 32'h0000_0306);
        wr(OFS_THR, 32'h0000_000f);
        line_chk(1'b0, 1'b1);
        wr(OFS_PRIO3, 32'h3000_0000);
        rd(OFS_PRIO3, 32'h3000_0000);
        unit_req <= 32'h8000_0030;
        wr(OFS_N_ENSET, 32'h8000_0000);
        rd(OFS_WIN, 32'h0000_031f);
        wr(OFS_N_ENCLR, 32'hffff_ffff);
        rd(OFS_WIN, 32'h0000_ffff);
    endtask
    task automatic t_trig();
        unit_req <= 32'h0000_0008;
        @(posedge clk);
        rd(OFS_N_RAW, 32'h0000_0008);
        unit_req <= 32'h0;
        @(posedge clk);
        rd(OFS_N_RAW, 32'h0);
        wr(OFS_N_MODE, 32'h0000_0008);
        rd(OFS_N_RAW, 32'h0);
        unit_req <= 32'h0000_0008;
        @(posedge clk);
        unit_req <= 32'h0;
        @(posedge clk);
        rd(OFS_N_RAW, 32'h0000_0008);
        wr(OFS_N_TRCLR, 32'h0000_0004);
        rd(OFS_N_RAW, 32'h0000_0008);
        wr(OFS_N_TRCLR, 32'h0000_0008);
        rd(OFS_N_RAW, 32'h0);
        wr(OFS_N_MODE, 32'h0);
        wr(OFS_N_POL, 32'hffff_fff7);
        rd(OFS_N_RAW, 32'h0000_0008);
        wr(OFS_N_POL, 32'hffff_ffff);
    endtask
    // The unit request on input 1 must be ignored
    task automatic t_soft();
        wr(OFS_SWREQ, 32'h0000_0002);
        rd(OFS_N_RAW, 32'h0000_0002);
        unit_req <= 32'h0000_0002;
        wr(OFS_SWREQ, 32'h0);
        rd(OFS_N_RAW, 32'h0);
        unit_req <= 32'h0;
    endtask
    task automatic t_pins();
        pins <= 8'hfb;
        repeat (4) @(posedge clk);
        rd(OFS_P_RAW, 32'h0000_0004);
        rd(OFS_N_RAW, 32'h0);
        wr(OFS_P_ENSET, 32'h0000_0004);
        rd(OFS_P_MSTAT, 32'h0000_0004);
        rd(OFS_N_RAW, 32'h0010_0000);
        wr(OFS_P_ENCLR, 32'h0000_0004);
        pins <= 8'hfe;
        repeat (4) @(posedge clk);
        rd(OFS_F_RAW, 32'h0000_0002);
        rd(OFS_F_MSTAT, 32'h0);
        wr(OFS_F_ENSET, 32'h0000_0003);
        line_chk(1'b1, 1'b0);
        pins    <= 8'hff;
        wdt_req <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OFS_F_MSTAT, 32'h0000_0001);
        wr(OFS_F_ENCLR, 32'h0000_0003);
        line_chk(1'b1, 1'b1);
        wdt_req <= 1'b0;
    endtask
    // Edge latch then polarity swap, first for the fast group, then for the pin group
    task automatic t_edge();
        wr(OFS_F_MODE, 32'h0000_0001);
        wdt_req <= 1'b1;
        @(posedge clk);
        wdt_req <= 1'b0;
        @(posedge clk);
        rd(OFS_F_RAW, 32'h0000_0001);
        wr(OFS_F_TRCLR, 32'h0000_0001);
        rd(OFS_F_RAW, 32'h0);
        wr(OFS_F_MODE, 32'h0);
        wr(OFS_F_POL, 32'h0000_0002);
        rd(OFS_F_RAW, 32'h0000_0001);
        wr(OFS_F_POL, 32'h0000_0003);
        wr(OFS_P_MODE, 32'h0000_0080);
        pins <= 8'h7f;
        repeat (4) @(posedge clk);
        pins <= 8'hff;
        repeat (4) @(posedge clk);
        rd(OFS_P_RAW, 32'h0000_0080);
        wr(OFS_P_TRCLR, 32'h0000_0080);
        rd(OFS_P_RAW, 32'h0);
        wr(OFS_P_MODE, 32'h0);
        wr(OFS_P_POL, 32'h0000_0f7f);
        rd(OFS_P_RAW, 32'h0000_0080);
        wr(OFS_P_POL, 32'h0000_0fff);
    endtask
    task automatic t_err();
        apb(1'b1, {BASE_HI, 12'h030}, 32'hffff_ffff);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b0, {BASE_HI, 12'h030}, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, 32'h0000_0004, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        rd(OFS_N_ENCLR, 32'h0);
        chk({24'h0, n_taken}, 32'h3);
        chk({24'h0, f_taken}, 32'h1);
    endtask
    // =====================================================
    // Clock, reset and main sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        unit_req = 32'h0;
        wdt_req = 1'b0;
        pins = 8'hff;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_enable();
        t_prio();
        t_trig();
        t_soft();
        t_pins();
        t_edge();
        t_err();
        end_sim();
    end
endmodule // pic_top_tb
